// *** src/fpc_defs.svh ***
// Offsets, field positions, reset values and lookup figures for the bank
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

`define FPC_OFS_IS_PIN_SHORT_CONFIG        8'h22
`define FPC_OFS_WDOG        8'h26
`define FPC_OFS_MASK_LO     8'h2c
`define FPC_OFS_MASK_HI     8'h2d
`define FPC_OFS_OTP         8'h2e
`define FPC_OFS_BSSC        8'h36
`define FPC_OFS_DCM         8'h3a

`define FPC_RST_IS_PIN_SHORT_CONFIG        8'h32
`define FPC_RST_WDOG        8'h01
`define FPC_RST_MASK        16'h0000
`define FPC_RST_OTP         8'h00
`define FPC_RST_BSSC        8'h02
`define FPC_RST_DCM         8'h00

`define FPC_IS_PIN_SHORT_CONFIG_FREQ_LSB   2
`define FPC_IS_PIN_SHORT_CONFIG_ILIM_LSB   4
`define FPC_BSSC_RESP_LSB   0
`define FPC_BSSC_SMPL_LSB   2
`define FPC_BSSC_ILIM_LSB   4
`define FPC_WDOG_LSB        0
`define FPC_OTP_HYS_BIT     0
`define FPC_DCM_EN_BIT      2
`define FPC_MASK_BITS       9

`define FPC_FREQ_C00_KHZ    8'h3c
`define FPC_FREQ_C01_KHZ    8'h1e
`define FPC_FREQ_C10_KHZ    8'h5a
`define FPC_FREQ_C11_KHZ    8'h78
`define FPC_IS_PIN_SHORT_CONFIG_STEP_SHIFT 4
`define FPC_BSW_C00         7'h30
`define FPC_BSW_C01         7'h20
`define FPC_BSW_C10         7'h40
`define FPC_BSW_C11         7'h48
`define FPC_HYS_LOW_DEGC    7'h28
`define FPC_HYS_HIGH_DEGC   7'h3c

`endif

// *** src/fpc_pkg.sv ***
// Types shared by the command register bank
`default_nettype none
package fpc_pkg;
  typedef enum logic [3:0] {
    FPC_IDLE, FPC_ADDR, FPC_ADDR_ACK, FPC_CMD, FPC_CMD_ACK,
    FPC_WDATA, FPC_WDATA_ACK, FPC_RDATA, FPC_RDATA_ACK
  } fpc_state_e;
endpackage
`default_nettype wire

// *** src/fpc_cfg_if.sv ***
// Stored register contents passed from the bank to the field decoder
`default_nettype none
interface fpc_cfg_if;
  logic [7:0]  is_pin_short_config;
  logic [7:0]  wdog;
  logic [15:0] mask;
  logic [7:0]  otp;
  logic [7:0]  bssc;
  logic [7:0]  dcm;
  modport src (output is_pin_short_config, wdog, mask, otp, bssc, dcm);
  modport dec (input is_pin_short_config, wdog, mask, otp, bssc, dcm);
endinterface
`default_nettype wire

// *** src/fpc_field_dec.sv ***
// Turns stored register fields into registered thresholds and enables
`include "fpc_defs.svh"
`default_nettype none
module fpc_field_dec
  import fpc_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Stored registers
  fpc_cfg_if.dec                         cfg,
  // Decoded settings
  output logic [7:0]                     is_short_freq_khz,
  output logic [6:0]                     is_short_ilim,
  output logic [6:0]                     bsw_short_ilim,
  output logic [2:0]                     bsw_short_samples,
  output logic [1:0]                     bsw_short_resp,
  output logic [`FPC_MASK_BITS-1:0]      irq_enable,
  output logic [6:0]                     otp_hys_degc,
  output logic [1:0]                     wdog_period_code,
  output logic                           discontinuous_only_enable
);
  logic [1:0] fcode;
  logic [2:0] icode;
  logic [1:0] bcode;
  logic [1:0] scode;
  logic [7:0] freq_nxt;
  logic [6:0] isl_nxt;
  logic [6:0] bsl_nxt;
  logic [2:0] smp_nxt;

  always_comb begin
    fcode = cfg.is_pin_short_config[`FPC_IS_PIN_SHORT_CONFIG_FREQ_LSB +: 2];
    icode = cfg.is_pin_short_config[`FPC_IS_PIN_SHORT_CONFIG_ILIM_LSB +: 3];
    bcode = cfg.bssc[`FPC_BSSC_ILIM_LSB +: 2];
    scode = cfg.bssc[`FPC_BSSC_SMPL_LSB +: 2];
    unique case (fcode)
      2'h0: freq_nxt = `FPC_FREQ_C00_KHZ;
      2'h1: freq_nxt = `FPC_FREQ_C01_KHZ;
      2'h2: freq_nxt = `FPC_FREQ_C10_KHZ;
      2'h3: freq_nxt = `FPC_FREQ_C11_KHZ;
    endcase
    // Code 000 has no listed level and decodes to zero
    isl_nxt = {icode, 4'h0};
    unique case (bcode)
      2'h0: bsl_nxt = `FPC_BSW_C00;
      2'h1: bsl_nxt = `FPC_BSW_C01;
      2'h2: bsl_nxt = `FPC_BSW_C10;
      2'h3: bsl_nxt = `FPC_BSW_C11;
    endcase
    smp_nxt = {1'b0, scode} + 3'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Same as the decode of the stored reset value, so no step on release
      is_short_freq_khz         <= `FPC_FREQ_C00_KHZ;
      is_short_ilim             <= 7'h30;
      bsw_short_ilim            <= `FPC_BSW_C00;
      bsw_short_samples         <= 3'h1;
      bsw_short_resp            <= 2'h2;
      irq_enable                <= '0;
      otp_hys_degc              <= `FPC_HYS_LOW_DEGC;
      wdog_period_code          <= 2'h1;
      discontinuous_only_enable <= 1'b0;
    end else begin
      is_short_freq_khz         <= freq_nxt;
      is_short_ilim             <= isl_nxt;
      bsw_short_ilim            <= bsl_nxt;
      bsw_short_samples         <= smp_nxt;
      // Code 11 is not a listed response; passed through unchanged
      bsw_short_resp            <= cfg.bssc[`FPC_BSSC_RESP_LSB +: 2];
      irq_enable                <= cfg.mask[`FPC_MASK_BITS-1:0];
      otp_hys_degc              <= cfg.otp[`FPC_OTP_HYS_BIT] ?
                                   `FPC_HYS_HIGH_DEGC :
                                   `FPC_HYS_LOW_DEGC;
      wdog_period_code          <= cfg.wdog[`FPC_WDOG_LSB +: 2];
      discontinuous_only_enable <= cfg.dcm[`FPC_DCM_EN_BIT];
    end
  end
endmodule // fpc_field_dec
`default_nettype wire

// *** src/fpc_cmd_regs.sv ***
// Two-wire serial slave and the fault protection command register bank
//
// How it works
// - IS-pin detect frequency code: 00=60k, 01=30k, 10=90k, 11=120k Hz.
// - IS-pin current limit from bits 6:4, code times sixteen.
// - Mask bit 8 mode flag, bits 0-2 OV, UV, short; resets zero.
// - Mask bit 4 peak load timer, bit 5 supply pin latch-off.
// - Mask bit 7 bus switch short, bit 6 secondary control event.
// - Bus switch threshold bits 5:4: 48, 32, 64, 72.
// - Bus switch samples code plus one; response bits 1:0; reset 0x02.
// - Over-temperature hysteresis 40 C when bit 0 clear, else 60 C.
`include "fpc_defs.svh"
`default_nettype none
module fpc_cmd_regs
  import fpc_pkg::*;
#(
  // Arbitrary seven-bit bus address
  parameter logic [6:0] DEV_ADDR = 7'h18
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Serial bus
  input  wire logic                      scl,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  // Decoded settings
  output logic [7:0]                     is_short_freq_khz,
  output logic [6:0]                     is_short_ilim,
  output logic [6:0]                     bsw_short_ilim,
  output logic [2:0]                     bsw_short_samples,
  output logic [1:0]                     bsw_short_resp,
  output logic [`FPC_MASK_BITS-1:0]      irq_enable,
  output logic [6:0]                     otp_hys_degc,
  output logic [1:0]                     wdog_period_code,
  output logic                           discontinuous_only_enable
);
  fpc_cfg_if cfg ();

  // Bus sampling
  logic       scl_r;
  logic       sda_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // Serial engine
  fpc_state_e state_r,  state_nxt;
  logic [2:0] cnt_r,    cnt_nxt;
  logic [7:0] shf_r,    shf_nxt;
  logic       full_r,   full_nxt;
  logic [7:0] ptr_r,    ptr_nxt;
  logic       oe_r,     oe_nxt;
  logic       mack_r,   mack_nxt;
  // Read data for the current and the following offset
  logic [7:0] rd_cur;
  logic [7:0] rd_inc;

  // Registers
  logic [7:0]  is_pin_short_config_r,  is_pin_short_config_nxt;
  logic [7:0]  wdog_r,  wdog_nxt;
  logic [15:0] mask_r,  mask_nxt;
  logic [7:0]  otp_r,   otp_nxt;
  logic [7:0]  bssc_r,  bssc_nxt;
  logic [7:0]  dcm_r,   dcm_nxt;

  // Only the mask reads back; write-only registers read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] ofs,
                                         input logic [15:0] m);
    logic [7:0] v;
    v = 8'h00;
    unique case (ofs)
      `FPC_OFS_MASK_LO: v = m[7:0];
      `FPC_OFS_MASK_HI: v = m[15:8];
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    scl_rise = scl & ~scl_r;
    scl_fall = ~scl & scl_r;
    start_c  = scl & scl_r & sda_r & ~sda_i;
    stop_c   = scl & scl_r & ~sda_r & sda_i;
  end

  always_comb begin
    rd_cur    = rd_byte(ptr_r, mask_r);
    rd_inc    = rd_byte(ptr_r + 8'h01, mask_r);
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shf_nxt   = shf_r;
    full_nxt  = full_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    mack_nxt  = mack_r;
    is_pin_short_config_nxt  = is_pin_short_config_r;
    wdog_nxt  = wdog_r;
    mask_nxt  = mask_r;
    otp_nxt   = otp_r;
    bssc_nxt  = bssc_r;
    dcm_nxt   = dcm_r;
    if (start_c) begin
      state_nxt = FPC_ADDR;
      cnt_nxt   = 3'h0;
      full_nxt  = 1'b0;
      oe_nxt    = 1'b0;
    end else if (stop_c) begin
      // A byte cut short by stop is dropped, never applied
      state_nxt = FPC_IDLE;
      oe_nxt    = 1'b0;
      full_nxt  = 1'b0;
    end else begin
      unique case (state_r)
        FPC_IDLE: begin
          oe_nxt = 1'b0;
        end
        FPC_ADDR, FPC_CMD, FPC_WDATA: begin
          if (scl_rise && !full_r) begin
            shf_nxt  = {shf_r[6:0], sda_i};
            cnt_nxt  = cnt_r + 3'h1;
            full_nxt = (cnt_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            oe_nxt   = 1'b1;
            unique case (state_r)
              FPC_ADDR: begin
                if (shf_r[7:1] == DEV_ADDR) begin
                  state_nxt = FPC_ADDR_ACK;
                  mack_nxt  = shf_r[0];
                end else begin
                  state_nxt = FPC_IDLE;
                  oe_nxt    = 1'b0;
                end
              end
              FPC_CMD: begin
                ptr_nxt   = shf_r;
                state_nxt = FPC_CMD_ACK;
              end
              default: state_nxt = FPC_WDATA_ACK;
            endcase
          end
        end
        FPC_ADDR_ACK, FPC_CMD_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (state_r == FPC_ADDR_ACK && mack_r) begin
              shf_nxt   = rd_cur;
              oe_nxt    = ~rd_cur[7];
              state_nxt = FPC_RDATA;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = (state_r == FPC_ADDR_ACK) ? FPC_CMD : FPC_WDATA;
            end
          end
        end
        FPC_WDATA_ACK: begin
          if (scl_fall) begin
            // Acknowledge clock complete: the byte is now committed
            oe_nxt    = 1'b0;
            cnt_nxt   = 3'h0;
            state_nxt = FPC_WDATA;
            ptr_nxt   = ptr_r + 8'h01;
            unique case (ptr_r)
              `FPC_OFS_IS_PIN_SHORT_CONFIG:    is_pin_short_config_nxt = shf_r;
              `FPC_OFS_WDOG:    wdog_nxt = shf_r;
              `FPC_OFS_MASK_LO: mask_nxt[7:0] = shf_r;
              `FPC_OFS_MASK_HI: mask_nxt[15:8] = shf_r;
              `FPC_OFS_OTP:     otp_nxt = shf_r;
              `FPC_OFS_BSSC:    bssc_nxt = shf_r;
              `FPC_OFS_DCM:     dcm_nxt = shf_r;
              default:          ;
            endcase
          end
        end
        FPC_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 3'h1;
          end else if (scl_fall) begin
            if (cnt_r == 3'h0) begin
              oe_nxt    = 1'b0;
              state_nxt = FPC_RDATA_ACK;
            end else begin
              shf_nxt = {shf_r[6:0], 1'b0};
              oe_nxt  = ~shf_r[6];
            end
          end
        end
        FPC_RDATA_ACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_i;
          end else if (scl_fall) begin
            if (mack_r) begin
              ptr_nxt   = ptr_r + 8'h01;
              shf_nxt   = rd_inc;
              oe_nxt    = ~rd_inc[7];
              state_nxt = FPC_RDATA;
            end else begin
              state_nxt = FPC_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_r   <= 1'b1;
      sda_r   <= 1'b1;
      state_r <= FPC_IDLE;
      cnt_r   <= 3'h0;
      shf_r   <= 8'h00;
      full_r  <= 1'b0;
      ptr_r   <= 8'h00;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
      sda_o   <= 1'b0;
      is_pin_short_config_r  <= `FPC_RST_IS_PIN_SHORT_CONFIG;
      wdog_r  <= `FPC_RST_WDOG;
      mask_r  <= `FPC_RST_MASK;
      otp_r   <= `FPC_RST_OTP;
      bssc_r  <= `FPC_RST_BSSC;
      dcm_r   <= `FPC_RST_DCM;
    end else begin
      scl_r   <= scl;
      sda_r   <= sda_i;
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shf_r   <= shf_nxt;
      full_r  <= full_nxt;
      ptr_r   <= ptr_nxt;
      oe_r    <= oe_nxt;
      mack_r  <= mack_nxt;
      sda_o   <= 1'b0;
      is_pin_short_config_r  <= is_pin_short_config_nxt;
      wdog_r  <= wdog_nxt;
      mask_r  <= mask_nxt;
      otp_r   <= otp_nxt;
      bssc_r  <= bssc_nxt;
      dcm_r   <= dcm_nxt;
    end
  end

  assign sda_oe   = oe_r;
  assign cfg.is_pin_short_config = is_pin_short_config_r;
  assign cfg.wdog = wdog_r;
  assign cfg.mask = mask_r;
  assign cfg.otp  = otp_r;
  assign cfg.bssc = bssc_r;
  assign cfg.dcm  = dcm_r;

  fpc_field_dec u_dec (
    .clk                       (clk),
    .rst                       (rst),
    .cfg                       (cfg),
    .is_short_freq_khz         (is_short_freq_khz),
    .is_short_ilim             (is_short_ilim),
    .bsw_short_ilim            (bsw_short_ilim),
    .bsw_short_samples         (bsw_short_samples),
    .bsw_short_resp            (bsw_short_resp),
    .irq_enable                (irq_enable),
    .otp_hys_degc              (otp_hys_degc),
    .wdog_period_code          (wdog_period_code),
    .discontinuous_only_enable (discontinuous_only_enable)
  );
endmodule // fpc_cmd_regs
`default_nettype wire

// *** verif/fpc_cmd_regs_chk.sv ***
// Port assertions for the command register bank
`default_nettype none
module fpc_cmd_regs_chk
  import fpc_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Serial bus
  input wire logic       scl,
  input wire logic       sda_oe,
  // Decoded settings
  input wire logic [7:0] is_short_freq_khz,
  input wire logic [6:0] is_short_ilim,
  input wire logic [6:0] bsw_short_ilim,
  input wire logic [2:0] bsw_short_samples,
  input wire logic [1:0] bsw_short_resp,
  input wire logic [8:0] irq_enable,
  input wire logic [6:0] otp_hys_degc
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_freq_table: assert property (
    is_short_freq_khz inside {8'h3c, 8'h1e, 8'h5a, 8'h78})
    else $error("freq off table");
  a_ilim_steps: assert property (
    is_short_ilim[3:0] == 4'h0 && is_short_ilim <= 7'h70)
    else $error("ilim not a step");
  a_bsw_ilim_set: assert property (
    bsw_short_ilim inside {7'h30, 7'h20, 7'h40, 7'h48})
    else $error("bus switch ilim off table");
  a_hys_pair: assert property (
    otp_hys_degc inside {7'h28, 7'h3c}) else $error("hys off table");
  a_mask_clear: assert property (
    $fell(rst) |-> irq_enable == 9'h000 ##1 irq_enable == 9'h000)
    else $error("mask not clear");
  a_bsw_reset: assert property (
    $fell(rst) |-> (bsw_short_samples == 3'h1 && bsw_short_resp == 2'h2)
      ##1 (bsw_short_samples == 3'h1 && bsw_short_resp == 2'h2))
    else $error("bus switch reset wrong");
  // Settings may only move just after the device acked a byte
  a_cfg_after_ack: assert property (
    $changed({is_short_ilim, bsw_short_ilim, bsw_short_samples,
      bsw_short_resp, irq_enable, otp_hys_degc}) |-> $past(sda_oe)
      || $past(sda_oe, 2) || $past(sda_oe, 3) || $past(sda_oe, 4))
    else $error("setting moved without ack");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl) else $error("sda moved with scl high");
endmodule // fpc_cmd_regs_chk
`default_nettype wire

// *** verif/fpc_bus_master.sv ***
// Bus master model standing in for the microcontroller
`default_nettype none
module fpc_bus_master
  import fpc_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h18,
  // Clocks per scl phase; raise it for a slow master
  parameter int         HALF = 4
) (
  // Clock
  input  wire logic clk,
  // Open-drain data line, pulled up
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Pins move only just after a falling clk edge
  task automatic step(input logic c, input logic o);
    scl = c;
    sda_oe = o;
    repeat (HALF) @(negedge clk);
  endtask
  // From idle, or as a repeated start from a low scl
  task automatic start();
    step(scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic bit_io(input logic b, output logic s);
    step(1'b0, ~b);
    step(1'b1, ~b);
    s = sda;
    step(1'b0, ~b);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
    bit_io(1'b1, ack);
    ack = ~ack;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] d,
                    input int n, output logic ok);
    logic a;
    start();
    tx({ADDR, 1'b0}, ok);
    tx(ofs, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      tx(d[8*i +: 8], a);
      ok &= a;
    end
    stop();
  endtask
  // Offset write, repeated start, then n bytes read, low byte first
  task automatic rd(input logic [7:0] ofs, input int n,
                    output logic [15:0] d, output logic ok);
    logic       a;
    logic [7:0] b;
    d = 16'h0000;
    start();
    tx({ADDR, 1'b0}, ok);
    tx(ofs, a);
    ok &= a;
    start();
    tx({ADDR, 1'b1}, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) bit_io(1'b1, b[j]);
      // Ack every byte but the last
      bit_io(i == n - 1, a);
      d[8*i +: 8] = b;
    end
    stop();
  endtask
endmodule // fpc_bus_master
`default_nettype wire

// *** verif/fpc_cmd_regs_tb.sv ***
// Bench for the command register bank, driven as bus master
`default_nettype none
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); \
  end \
end
module fpc_cmd_regs_tb
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, scl, m_oe, sda, sda_o, sda_oe, ok, dcm;
  logic [7:0] freq;
  logic [6:0] is_ilim, bsw_ilim, hys;
  logic [2:0] smp;
  logic [1:0] resp, wdc;
  logic [8:0] irq;
  logic [15:0] rdat;
  int         errors, samples_checked;
  logic [7:0] frq_t [4] = '{8'h3c, 8'h1e, 8'h5a, 8'h78};
  logic [6:0] bsw_t [4] = '{7'h30, 7'h20, 7'h40, 7'h48};
  assign sda = ~(sda_oe | m_oe);
  fpc_cmd_regs DUT (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .is_short_freq_khz(freq), .is_short_ilim(is_ilim),
    .bsw_short_ilim(bsw_ilim), .bsw_short_samples(smp),
    .bsw_short_resp(resp), .irq_enable(irq), .otp_hys_degc(hys),
    .wdog_period_code(wdc), .discontinuous_only_enable(dcm)
  );
  fpc_bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic w(input logic [7:0] o, input logic [15:0] d, input int n);
    m.wr(o, d, n, ok);
    `CHK("ack", 1'b1, ok)
    repeat (4) @(negedge clk);
  endtask
  task automatic chk_rst();
    `CHK("irq", 9'h000, irq)
    `CHK("sda_o", 1'b0, sda_o)
    `CHK("resp", 2'h2, resp)
    `CHK("samples", 3'h1, smp)
    `CHK("hys", 7'h28, hys)
    `CHK("freq", 8'h3c, freq)
    `CHK("ilim", 7'h30, is_ilim)
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_rst();
    for (int c = 0; c < 4; c++) begin
      w(8'h22, {8'h00, 1'b0, 3'(2 * c + 1), 2'(c), 2'b00}, 1);
      `CHK("freq", frq_t[c], freq)
      `CHK("ilim", 7'(32 * c + 16), is_ilim)
      w(8'h36, {8'h00, 2'b00, 2'(c), 2'(c), 2'(c)}, 1);
      `CHK("bsw ilim", bsw_t[c], bsw_ilim)
      `CHK("samples", 3'(c + 1), smp)
      `CHK("resp", 2'(c), resp)
    end
    w(8'h2e, 16'h0001, 1);
    `CHK("hys", 7'h3c, hys)
    // A byte cut short by stop must leave the old value
    m.start();
    m.tx({7'h18, 1'b0}, ok);
    m.tx(8'h2e, ok);
    repeat (7) m.bit_io(1'b0, ok);
    m.stop();
    `CHK("hys", 7'h3c, hys)
    w(8'h2e, 16'h0000, 1);
    `CHK("hys", 7'h28, hys)
    w(8'h2c, 16'h01b5, 2);
    `CHK("irq", 9'h1b5, irq)
    m.rd(8'h2c, 2, rdat, ok);
    `CHK("rd ack", 1'b1, ok)
    `CHK("mask rd", 16'h01b5, rdat)
    // Write-only registers read back as zero
    m.rd(8'h22, 1, rdat, ok);
    `CHK("wo rd", 16'h0000, rdat)
    w(8'h2c, 16'h004a, 2);
    `CHK("irq", 9'h04a, irq)
    w(8'h30, 16'h00ff, 1);
    `CHK("irq", 9'h04a, irq)
    m.start();
    m.tx({7'h19, 1'b0}, ok);
    m.stop();
    `CHK("nack", 1'b0, ok)
    w(8'h26, 16'h0003, 1);
    `CHK("wdog", 2'h3, wdc)
    w(8'h3a, 16'h0004, 1);
    `CHK("dcm", 1'b1, dcm)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_rst();
    report_and_stop();
  end
endmodule // fpc_cmd_regs_tb
bind fpc_cmd_regs fpc_cmd_regs_chk u_chk (
  .clk(clk), .rst(rst), .scl(scl), .sda_oe(sda_oe),
  .is_short_freq_khz(is_short_freq_khz), .is_short_ilim(is_short_ilim),
  .bsw_short_ilim(bsw_short_ilim), .bsw_short_samples(bsw_short_samples),
  .bsw_short_resp(bsw_short_resp), .irq_enable(irq_enable),
  .otp_hys_degc(otp_hys_degc)
);
`default_nettype wire
